// ===== ism_mailbox_smbus.sv
// i2c slave with mailboxes, alert response and a small smbus master
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ism_consts.svh"
module ism_mailbox_smbus (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // apb slave
   input wire ism_pkg::ism_apb_s apb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // i2c open-drain pins
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sclOut,
   output logic sdaOut,
   output var ism_pkg::ism_pin_s pinOe,
   // interrupt controller request
   output logic irqReq
);
   function automatic logic [7:0] byteSel(input logic [31:0] w, input logic [1:0] i);
      case (i)
         2'h0: byteSel = w[7:0];
         2'h1: byteSel = w[15:8];
         2'h2: byteSel = w[23:16];
         default: byteSel = w[31:24];
      endcase
   endfunction : byteSel

   logic sclPrev, sdaPrev, startSeen, stopSeen, sclRise, sclFall;
   ism_pkg::ism_slv_e sState, next_sState;
   logic [3:0] sCnt, next_sCnt;
   logic [7:0] sShift, next_sShift, sTx, next_sTx, sPa, next_sPa, txByte;
   logic sGotPa, next_sGotPa, sRw, next_sRw, sAlert, next_sAlert;
   logic sDrive, next_sDrive, sInWr, next_sInWr, sOutRd, next_sOutRd;
   logic evIn, evOut, evAlClr, inWe;
   ism_pkg::ism_mst_e mState, next_mState;
   logic [1:0] mPh, next_mPh;
   logic [3:0] mBit, next_mBit;
   logic [2:0] mIdx, next_mIdx, mNum, next_mNum;
   logic [7:0] mSh, next_mSh;
   logic mSclOe, next_mSclOe, mSdaOe, next_mSdaOe, mNack, next_mNack;
   logic [6:0] divCnt, next_divCnt;
   logic tick, mGo;
   logic [6:0] ownAddr, next_ownAddr;
   logic alertEn, next_alertEn, alertFlag, next_alertFlag;
   logic inFlag, next_inFlag, outFlag, next_outFlag;
   logic [1:0] irqStat, next_irqStat, irqEn, next_irqEn;
   logic [31:0] inMbox, next_inMbox, outMbox, next_outMbox, mData, next_mData;
   logic [31:0] next_prdata, rdWord;
   logic next_pslverr, next_irqReq, unmapped, setup, acc, wr, rd, outWr, inRd;

   // bus condition detection, inputs already synchronous
   assign sclRise = sclIn & ~sclPrev;
   assign sclFall = ~sclIn & sclPrev;
   assign startSeen = sclIn & sclPrev & sdaPrev & ~sdaIn;
   assign stopSeen = sclIn & sclPrev & ~sdaPrev & sdaIn;
   assign pready = 1'b1;
   assign sclOut = 1'b0;
   assign sdaOut = 1'b0;
   assign pinOe.sclOe = mSclOe;
   assign pinOe.sdaOe = sDrive | mSdaOe;

   always_comb begin
      if (sAlert) txByte = {ownAddr, 1'b0};
      else if (sPa[7:2] == `ISM_PA_STAT) txByte = {5'h00, outFlag, inFlag, alertFlag};
      else if (sPa[7:2] == `ISM_PA_IN) txByte = byteSel(inMbox, sPa[1:0]);
      else if (sPa[7:2] == `ISM_PA_OUT) txByte = byteSel(outMbox, sPa[1:0]);
      else txByte = 8'h00;
   end

   // slave bus engine
   always_comb begin
      next_sState = sState;
      next_sCnt = sCnt;
      next_sShift = sShift;
      next_sTx = sTx;
      next_sPa = sPa;
      next_sGotPa = sGotPa;
      next_sRw = sRw;
      next_sAlert = sAlert;
      next_sDrive = sDrive;
      next_sInWr = sInWr;
      next_sOutRd = sOutRd;
      evIn = 1'b0;
      evOut = 1'b0;
      evAlClr = 1'b0;
      inWe = 1'b0;
      if (stopSeen) begin
         next_sState = ism_pkg::S_IDLE;
         next_sDrive = 1'b0;
         evIn = sInWr;
         evOut = sOutRd;
         next_sInWr = 1'b0;
         next_sOutRd = 1'b0;
      end else if (startSeen) begin
         // restart bus logic only, registers untouched
         next_sState = ism_pkg::S_ADDR;
         next_sCnt = 4'h0;
         next_sGotPa = 1'b0;
         next_sAlert = 1'b0;
         next_sDrive = 1'b0;
      end else begin
         case (sState)
            ism_pkg::S_ADDR: begin
               if (sclRise) begin
                  next_sShift = {sShift[6:0], sdaIn};
                  next_sCnt = sCnt + 4'h1;
               end else if (sclFall && sCnt == `ISM_BITS) begin
                  next_sRw = sShift[0];
                  if (sShift[7:1] == ownAddr) begin
                     next_sState = ism_pkg::S_AACK;
                     next_sDrive = 1'b1;
                  end else if (sShift[7:1] == `ISM_ARA && sShift[0] && alertEn && alertFlag) begin
                     next_sState = ism_pkg::S_AACK;
                     next_sAlert = 1'b1;
                     next_sDrive = 1'b1;
                  end else begin
                     next_sState = ism_pkg::S_IDLE;
                  end
               end
            end
            ism_pkg::S_AACK: begin
               if (sclFall) begin
                  next_sCnt = 4'h0;
                  if (sRw) begin
                     next_sTx = txByte;
                     next_sDrive = ~txByte[7];
                     next_sState = ism_pkg::S_RD;
                  end else begin
                     next_sDrive = 1'b0;
                     next_sState = ism_pkg::S_WR;
                  end
               end
            end
            ism_pkg::S_WR: begin
               if (sclRise) begin
                  next_sShift = {sShift[6:0], sdaIn};
                  next_sCnt = sCnt + 4'h1;
               end else if (sclFall && sCnt == `ISM_BITS) begin
                  next_sDrive = 1'b1;
                  next_sState = ism_pkg::S_WACK;
                  if (!sGotPa) begin
                     next_sPa = sShift;
                     next_sGotPa = 1'b1;
                  end else begin
                     // plain data byte, never a check byte
                     if (sPa[7:2] == `ISM_PA_IN) begin
                        inWe = 1'b1;
                        next_sInWr = 1'b1;
                     end
                     next_sPa = sPa + 8'h01;
                  end
               end
            end
            ism_pkg::S_WACK: begin
               if (sclFall) begin
                  next_sDrive = 1'b0;
                  next_sCnt = 4'h0;
                  next_sState = ism_pkg::S_WR;
               end
            end
            ism_pkg::S_RD: begin
               if (sclFall) begin
                  if (sCnt == `ISM_LAST) begin
                     next_sDrive = 1'b0;
                     next_sState = ism_pkg::S_RACK;
                     if (sAlert) evAlClr = 1'b1;
                     else begin
                        if (sPa[7:2] == `ISM_PA_OUT) next_sOutRd = 1'b1;
                        next_sPa = sPa + 8'h01;
                     end
                  end else begin
                     next_sTx = {sTx[6:0], 1'b0};
                     next_sDrive = ~sTx[6];
                     next_sCnt = sCnt + 4'h1;
                  end
               end
            end
            ism_pkg::S_RACK: begin
               if (sclRise && sdaIn) next_sState = ism_pkg::S_IDLE;
               else if (sclFall) begin
                  next_sTx = txByte;
                  next_sDrive = ~txByte[7];
                  next_sCnt = 4'h0;
                  next_sState = ism_pkg::S_RD;
               end
            end
            default: next_sState = ism_pkg::S_IDLE;
         endcase
      end
   end

   // smbus master: quick command and short block write
   assign tick = (divCnt == 7'h00);
   assign mGo = wr && apb.paddr == `ISM_A_MCMD && mState == ism_pkg::M_IDLE;
   always_comb begin
      next_mState = mState;
      next_mPh = mPh;
      next_mBit = mBit;
      next_mIdx = mIdx;
      next_mNum = mNum;
      next_mSh = mSh;
      next_mSclOe = mSclOe;
      next_mSdaOe = mSdaOe;
      next_mNack = mNack;
      next_divCnt = tick ? 7'(`ISM_QTR_CYC - 1) : divCnt - 7'h01;
      case (mState)
         ism_pkg::M_IDLE: begin
            next_mPh = 2'h0;
            if (mGo) begin
               next_mSh = {apb.pwdata[6:0], apb.pwdata[`ISM_B_RD]};
               if (apb.pwdata[`ISM_B_RD]) next_mNum = 3'h0;
               else if (apb.pwdata[10:8] > `ISM_BLK_MAX) next_mNum = `ISM_BLK_MAX;
               else next_mNum = apb.pwdata[10:8];
               next_mIdx = 3'h0;
               next_mBit = 4'h0;
               next_mNack = 1'b0;
               next_mState = ism_pkg::M_START;
            end
         end
         ism_pkg::M_START: if (tick) begin
            next_mPh = mPh + 2'h1;
            if (mPh == 2'h0) next_mSdaOe = 1'b1;
            else begin
               next_mSclOe = 1'b1;
               next_mPh = 2'h0;
               next_mState = ism_pkg::M_BIT;
            end
         end
         ism_pkg::M_BIT: if (tick) begin
            next_mPh = mPh + 2'h1;
            case (mPh)
               2'h0: next_mSdaOe = (mBit == `ISM_BITS) ? 1'b0 : ~mSh[7];
               2'h1: next_mSclOe = 1'b0;
               2'h2: if (mBit == `ISM_BITS) next_mNack = sdaIn;
               default: begin
                  next_mSclOe = 1'b1;
                  if (mBit != `ISM_BITS) begin
                     next_mSh = {mSh[6:0], 1'b0};
                     next_mBit = mBit + 4'h1;
                  end else if (mNack || mIdx == mNum) begin
                     next_mState = ism_pkg::M_STOP;
                  end else begin
                     next_mSh = byteSel(mData, mIdx[1:0]);
                     next_mIdx = mIdx + 3'h1;
                     next_mBit = 4'h0;
                  end
               end
            endcase
         end
         ism_pkg::M_STOP: if (tick) begin
            next_mPh = mPh + 2'h1;
            case (mPh)
               2'h0: next_mSdaOe = 1'b1;
               2'h1: next_mSclOe = 1'b0;
               2'h2: next_mSdaOe = 1'b0;
               default: next_mState = ism_pkg::M_IDLE;
            endcase
         end
         default: next_mState = ism_pkg::M_IDLE;
      endcase
   end

   // apb registers, mailboxes and flags
   assign setup = apb.psel & ~apb.penable;
   assign acc = apb.psel & apb.penable;
   assign wr = acc & apb.pwrite;
   assign rd = acc & ~apb.pwrite;
   assign outWr = wr && apb.paddr == `ISM_A_MBOUT;
   assign inRd = rd && apb.paddr == `ISM_A_MBIN;
   always_comb begin
      next_ownAddr = ownAddr;
      next_alertEn = alertEn;
      next_irqEn = irqEn;
      next_outMbox = outMbox;
      next_mData = mData;
      next_inMbox = inMbox;
      next_prdata = prdata;
      next_pslverr = pslverr;
      unmapped = 1'b0;
      case (apb.paddr)
         `ISM_A_CTRL: rdWord = {24'h000000, alertEn, ownAddr};
         `ISM_A_STAT: rdWord = {25'h0, mNack, mState != ism_pkg::M_IDLE,
                                alertFlag, outFlag, inFlag, irqStat};
         `ISM_A_IEN: rdWord = {30'h0, irqEn};
         `ISM_A_MBIN: rdWord = inMbox;
         `ISM_A_MBOUT: rdWord = outMbox;
         `ISM_A_MCMD: rdWord = 32'h00000000;
         `ISM_A_MDATA: rdWord = mData;
         default: begin
            rdWord = 32'h00000000;
            unmapped = 1'b1;
         end
      endcase
      if (setup) begin
         next_prdata = rdWord;
         next_pslverr = unmapped;
      end
      if (wr && apb.paddr == `ISM_A_CTRL) begin
         next_ownAddr = apb.pwdata[6:0];
         next_alertEn = apb.pwdata[`ISM_B_ALEN];
      end
      if (wr && apb.paddr == `ISM_A_IEN) next_irqEn = apb.pwdata[1:0];
      if (outWr) next_outMbox = apb.pwdata;
      if (wr && apb.paddr == `ISM_A_MDATA) next_mData = apb.pwdata;
      if (inWe) begin
         case (sPa[1:0])
            2'h0: next_inMbox[7:0] = sShift;
            2'h1: next_inMbox[15:8] = sShift;
            2'h2: next_inMbox[23:16] = sShift;
            default: next_inMbox[31:24] = sShift;
         endcase
      end
      // set beats clear; flags move only on their own events
      next_inFlag = evIn | (inFlag & ~inRd);
      next_outFlag = outWr | (outFlag & ~evOut);
      next_alertFlag = (wr && apb.paddr == `ISM_A_CTRL && apb.pwdata[`ISM_B_ALSET])
                       | (alertFlag & ~evAlClr);
      next_irqStat[0] = evIn | (irqStat[0] & ~(wr && apb.paddr == `ISM_A_STAT && apb.pwdata[0]));
      next_irqStat[1] = evOut | (irqStat[1] & ~(wr && apb.paddr == `ISM_A_STAT && apb.pwdata[1]));
      next_irqReq = |(next_irqStat & next_irqEn);
   end

   // every flop to its default on chip reset
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
         sState <= ism_pkg::S_IDLE;
         sCnt <= 4'h0;
         sShift <= 8'h00;
         sTx <= 8'h00;
         sPa <= 8'h00;
         sGotPa <= 1'b0;
         sRw <= 1'b0;
         sAlert <= 1'b0;
         sDrive <= 1'b0;
         sInWr <= 1'b0;
         sOutRd <= 1'b0;
         mState <= ism_pkg::M_IDLE;
         mPh <= 2'h0;
         mBit <= 4'h0;
         mIdx <= 3'h0;
         mNum <= 3'h0;
         mSh <= 8'h00;
         mSclOe <= 1'b0;
         mSdaOe <= 1'b0;
         mNack <= 1'b0;
         divCnt <= 7'h00;
         ownAddr <= `ISM_OWN_RST;
         alertEn <= 1'b0;
         alertFlag <= 1'b0;
         inFlag <= 1'b0;
         outFlag <= 1'b0;
         irqStat <= 2'h0;
         irqEn <= 2'h0;
         inMbox <= 32'h00000000;
         outMbox <= 32'h00000000;
         mData <= 32'h00000000;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
         irqReq <= 1'b0;
      end else begin
         sclPrev <= sclIn;
         sdaPrev <= sdaIn;
         sState <= next_sState;
         sCnt <= next_sCnt;
         sShift <= next_sShift;
         sTx <= next_sTx;
         sPa <= next_sPa;
         sGotPa <= next_sGotPa;
         sRw <= next_sRw;
         sAlert <= next_sAlert;
         sDrive <= next_sDrive;
         sInWr <= next_sInWr;
         sOutRd <= next_sOutRd;
         mState <= next_mState;
         mPh <= next_mPh;
         mBit <= next_mBit;
         mIdx <= next_mIdx;
         mNum <= next_mNum;
         mSh <= next_mSh;
         mSclOe <= next_mSclOe;
         mSdaOe <= next_mSdaOe;
         mNack <= next_mNack;
         divCnt <= next_divCnt;
         ownAddr <= next_ownAddr;
         alertEn <= next_alertEn;
         alertFlag <= next_alertFlag;
         inFlag <= next_inFlag;
         outFlag <= next_outFlag;
         irqStat <= next_irqStat;
         irqEn <= next_irqEn;
         inMbox <= next_inMbox;
         outMbox <= next_outMbox;
         mData <= next_mData;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
         irqReq <= next_irqReq;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   property p_start_addr;
      !stopSeen && startSeen |=> sState == ism_pkg::S_ADDR && sCnt == 4'h0;
   endproperty
   a_start_addr: assert property (p_start_addr) else $error("start did not restart");
   property p_start_keep;
      startSeen && !apb.psel |=> $stable(inMbox) && $stable(inFlag) && $stable(outFlag);
   endproperty
   a_start_keep: assert property (p_start_keep) else $error("start touched registers");
   property p_in_set;
      stopSeen && sInWr |=> inFlag && irqStat[0];
   endproperty
   a_in_set: assert property (p_in_set) else $error("incoming mail not flagged");
   property p_irq_gate;
      !irqEn[0] && !(irqStat[1] && irqEn[1]) |-> !irqReq;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enable");
   property p_in_clr;
      inRd && !evIn |=> !inFlag;
   endproperty
   a_in_clr: assert property (p_in_clr) else $error("incoming flag not cleared");
   property p_out_set;
      outWr |=> outFlag && outMbox == $past(apb.pwdata);
   endproperty
   a_out_set: assert property (p_out_set) else $error("outgoing flag not set");
   property p_out_clr;
      stopSeen && sOutRd && !outWr |=> !outFlag && irqStat[1];
   endproperty
   a_out_clr: assert property (p_out_clr) else $error("outgoing flag not cleared");
   property p_blk_max;
      mState != ism_pkg::M_IDLE |-> mNum <= `ISM_BLK_MAX;
   endproperty
   a_blk_max: assert property (p_blk_max) else $error("block write too long");
   property p_ara_nack;
      sState == ism_pkg::S_ADDR && sclFall && !startSeen && !stopSeen && sCnt == `ISM_BITS
      && sShift == {`ISM_ARA, 1'b1} && !(alertEn && alertFlag) |=> sState == ism_pkg::S_IDLE;
   endproperty
   a_ara_nack: assert property (p_ara_nack) else $error("alert address not refused");
endmodule : ism_mailbox_smbus
`default_nettype wire

// ===== ism_consts.svh
// constants for the i2c slave mailbox and smbus block
`ifndef ISM_CONSTS_SVH
`define ISM_CONSTS_SVH
`define ISM_A_CTRL 8'h00
`define ISM_A_STAT 8'h04
`define ISM_A_IEN 8'h08
`define ISM_A_MBIN 8'h0c
`define ISM_A_MBOUT 8'h10
`define ISM_A_MCMD 8'h14
`define ISM_A_MDATA 8'h18
`define ISM_PA_STAT 6'h00
`define ISM_PA_IN 6'h01
`define ISM_PA_OUT 6'h02
`define ISM_ARA 7'h0c
`define ISM_OWN_RST 7'h50
`define ISM_BITS 4'h8
`define ISM_LAST 4'h7
`define ISM_BLK_MAX 3'h4
`define ISM_B_ALEN 7
`define ISM_B_ALSET 8
`define ISM_B_RD 7
`define ISM_CLK_NS 20
`define ISM_QTR_NS 2500
`define ISM_QTR_CYC (`ISM_QTR_NS / `ISM_CLK_NS)
`endif

// ===== ism_pkg.sv
// types for the i2c slave mailbox and smbus block
`default_nettype none
package ism_pkg;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_ADDR = 3'b001, S_AACK = 3'b010, S_WR = 3'b011,
      S_WACK = 3'b100, S_RD = 3'b101, S_RACK = 3'b110
   } ism_slv_e;
   typedef enum logic [1:0] {
      M_IDLE = 2'b00, M_START = 2'b01, M_BIT = 2'b10, M_STOP = 2'b11
   } ism_mst_e;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } ism_apb_s;
   typedef struct packed {
      logic sclOe;
      logic sdaOe;
   } ism_pin_s;
endpackage : ism_pkg
`default_nettype wire

// ===== ism_bus_partner.sv
// target model on the i2c lines for the block's own smbus master
`timescale 1ns/1ps
`default_nettype none
module ism_bus_partner #(
   parameter logic [6:0] TGT = 7'h3a
) (
   // line levels and bench master activity
   input wire logic scl,
   input wire logic sda,
   input wire logic busy,
   // pull-down on sda
   output logic sdaDn
);
   logic act = 1'b0, fresh = 1'b0;
   logic [7:0] sh = 8'h00, first = 8'h00;
   int bits = 0, bytes = 0;
   initial sdaDn = 1'b0;
   // frames opened by the bench's own master are ignored
   always @(sda) begin
      if (scl && !busy) begin
         act = !sda;
         bits = 0;
         fresh = 1'b1;
      end
   end
   always @(posedge scl) begin
      sh = {sh[6:0], sda};
      bits++;
   end
   // acks its own address and every data byte, expects no pec byte
   always @(negedge scl) begin
      if (act && bits == 8) begin
         bytes++;
         sdaDn <= !fresh || sh[7:1] == TGT;
         first = fresh ? sh : first;
         fresh = 1'b0;
      end
      if (act && bits == 9) begin
         sdaDn <= 1'b0;
         bits = 0;
         act = !first[0] && first[7:1] == TGT;
      end
   end
endmodule : ism_bus_partner
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the i2c slave mailbox and smbus block
`timescale 1ns/1ps
`default_nettype none
`include "ism_consts.svh"
module testbench;
   localparam logic [6:0] TGT = 7'h3a;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   ism_pkg::ism_apb_s apb = '0;
   ism_pkg::ism_pin_s pinOe;
   logic pready, pslverr, sclOut, sdaOut, irqReq, tDn, k;
   logic mDn = 1'b0, cDn = 1'b0, own = 1'b0;
   logic [31:0] prdata, d1, d2, r;
   logic [7:0] q;
   wire scl = (pinOe.sclOe ? sclOut : 1'b1) & !cDn;
   wire sda = (pinOe.sdaOe ? sdaOut : 1'b1) & !mDn & !tDn;
   int mismatches = 0, checked = 0;
   logic [32:0] notes[$];
   logic [10:0] cmd[4] = '{{4'h0, TGT}, {4'he, TGT}, {4'h1, TGT}, {4'h4, TGT + 7'h1}};
   int nb[4] = '{1, 6, 7, 8};
   always #10 sys_clk = ~sys_clk;
   ism_mailbox_smbus u_ism_mailbox_smbus (.sys_clk(sys_clk), .rstn(rstn), .apb(apb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .sclIn(scl), .sdaIn(sda),
      .sclOut(sclOut), .sdaOut(sdaOut), .pinOe(pinOe), .irqReq(irqReq));
   ism_bus_partner #(.TGT(TGT)) u_ism_bus_partner (.scl(scl), .sda(sda), .busy(own),
      .sdaDn(tDn));
   function automatic logic [31:0] step(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : step
   task automatic check(input string what, input logic [32:0] e, input logic [32:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask : check
   task automatic results();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results
   // apb master: setup, access until pready, then one idle cycle
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      apb.psel <= 1'b1;
      apb.pwrite <= w;
      apb.paddr <= a;
      apb.pwdata <= d;
      @(posedge sys_clk);
      apb.penable <= 1'b1;
      @(posedge sys_clk iff pready === 1'b1);
      r = prdata;
      apb.psel <= 1'b0;
      apb.penable <= 1'b0;
      @(posedge sys_clk);
   endtask : xfer
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      notes.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask : rd
   always @(posedge sys_clk) begin
      if (notes.size() != 0 && apb.psel && apb.penable && pready) begin
         check("apb read", notes.pop_front(), {pslverr, prdata});
      end
   end
   task automatic irqIs(input logic e);
      @(negedge sys_clk);
      check("irq", e, irqReq);
      @(posedge sys_clk);
   endtask : irqIs
   // bench i2c master, a third of a bit is eight clocks
   task automatic sig(input logic m, input logic c);
      mDn <= m;
      cDn <= c;
      repeat (8) @(posedge sys_clk);
   endtask : sig
   task automatic start();
      own = 1'b1;
      sig(1'b0, cDn);
      sig(1'b0, 1'b0);
      sig(1'b1, 1'b0);
      sig(1'b1, 1'b1);
   endtask : start
   task automatic stop();
      sig(1'b1, 1'b1);
      sig(1'b1, 1'b0);
      sig(1'b0, 1'b0);
      own = 1'b0;
   endtask : stop
   task automatic bitIo(input logic b, output logic s);
      sig(!b, 1'b1);
      sig(!b, 1'b0);
      s = sda;
      sig(!b, 1'b1);
   endtask : bitIo
   task automatic io(input logic [7:0] d, input logic a, output logic [7:0] v, output logic s);
      for (int i = 7; i >= 0; i--) begin
         bitIo(d[i], v[i]);
      end
      bitIo(a, s);
   endtask : io
   task automatic iwr(input logic [31:0] d);
      logic n;
      start();
      io({`ISM_OWN_RST, 1'b0}, 1'b1, q, n);
      io(8'h04, 1'b1, q, k);
      n = n | k;
      for (int i = 0; i < 4; i++) begin
         io(d[8 * i +: 8], 1'b1, q, k);
         n = n | k;
      end
      stop();
      check("write acks", 1'b0, n);
   endtask : iwr
   // read n bytes from address byte a, after setting the pa when pa is not negative
   task automatic ird(input logic [7:0] a, input int pa, input int n);
      logic j;
      r = 32'h0;
      start();
      if (pa >= 0) begin
         io({`ISM_OWN_RST, 1'b0}, 1'b1, q, k);
         io(pa[7:0], 1'b1, q, k);
         start();
      end
      io(a, 1'b1, q, k);
      for (int i = 0; i < n && !k; i++) begin
         io(8'hff, i == n - 1, q, j);
         r[8 * i +: 8] = q;
      end
      stop();
   endtask : ird
   initial begin
      repeat (90000) @(posedge sys_clk);
      mismatches++;
      results();
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      rd(`ISM_A_CTRL, 33'h50);
      rd(`ISM_A_STAT, 33'h0);
      rd(`ISM_A_IEN, 33'h0);
      rd(8'h1c, 33'h100000000);
      d1 = step(32'h8b5f22e1);
      d2 = step(d1);
      xfer(1'b1, `ISM_A_IEN, 32'h2);
      start();
      io({`ISM_OWN_RST, 1'b0}, 1'b1, q, k);
      bitIo(1'b0, k);
      iwr(d1);
      iwr(d2);
      irqIs(1'b0);
      rd(`ISM_A_STAT, 33'h5);
      ird(8'ha1, 0, 1);
      check("slave status", 32'h2, r);
      xfer(1'b1, `ISM_A_IEN, 32'h3);
      irqIs(1'b1);
      rd(`ISM_A_MBIN, {1'b0, d2});
      rd(`ISM_A_STAT, 33'h1);
      xfer(1'b1, `ISM_A_STAT, 32'h1);
      irqIs(1'b0);
      xfer(1'b1, `ISM_A_MBOUT, d1);
      xfer(1'b1, `ISM_A_MBOUT, d2);
      rd(`ISM_A_STAT, 33'h8);
      ird(8'ha1, 8, 4);
      check("outgoing mail", d2, r);
      rd(`ISM_A_STAT, 33'h2);
      irqIs(1'b1);
      ird(8'h19, -1, 1);
      check("alert nack", 1'b1, k);
      xfer(1'b1, `ISM_A_CTRL, 32'h1d0);
      rd(`ISM_A_STAT, 33'h12);
      ird(8'h19, -1, 1);
      check("alert reply", {1'b0, 8'ha0}, {k, r[7:0]});
      rd(`ISM_A_STAT, 33'h2);
      xfer(1'b1, `ISM_A_MDATA, d1);
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, `ISM_A_MCMD, {21'h0, cmd[i]});
         do xfer(1'b0, `ISM_A_STAT, 32'h0); while (r[5] !== 1'b0);
         check("master bytes", nb[i], u_ism_bus_partner.bytes);
         check("master nack", i == 3, r[6]);
         check("address", {cmd[i][6:0], cmd[i][7]}, u_ism_bus_partner.first);
      end
      // chip reset while the slave drives a status byte
      start();
      io({`ISM_OWN_RST, 1'b0}, 1'b1, q, k);
      io(8'h00, 1'b1, q, k);
      start();
      io({`ISM_OWN_RST, 1'b1}, 1'b1, q, k);
      bitIo(1'b1, k);
      check("slave drive", 1'b0, k);
      rstn <= 1'b0;
      @(negedge sys_clk);
      check("sda released", 1'b0, pinOe.sdaOe);
      @(posedge sys_clk);
      rstn <= 1'b1;
      stop();
      rd(`ISM_A_CTRL, 33'h50);
      rd(`ISM_A_STAT, 33'h0);
      results();
   end
endmodule : testbench
`default_nettype wire
